// ---- tb/bitstr_unit_monitor.sv ----
// Checker on the top ports of the bit-string unit.
// Assumes hready is the unit's own hreadyout.
`timescale 1ns/10ps
module bitstr_unit_monitor
    import bitstr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Flags
    input wire logic busy,
    input wire logic ok_out,
    input wire logic last_shifted_out_bit,
    input wire logic test_out
);
    // ****************************************
    // Data phase tracking
    // ****************************************
    logic ap_r;
    logic wr_r;
    logic [11:0] a_r;
    logic en_r;
    logic [2:0] op_r;
    logic [8:0] bcnt_r;
    wire scan_dp = ap_r && wr_r && a_r == SCAN_OFF;
    // Writes while busy are dropped, so the mirror skips them too
    wire ctrl_dp = ap_r && wr_r && a_r == CTRL_OFF && !busy;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_r <= 1'b0;
            wr_r <= 1'b0;
            a_r <= 12'h000;
            en_r <= 1'b0;
            op_r <= 3'h0;
            bcnt_r <= 9'h000;
        end else begin
            ap_r <= hsel && hready && htrans[1];
            wr_r <= hwrite;
            a_r <= haddr[11:0];
            en_r <= ctrl_dp ? hwdata[CTRL_EN] : en_r;
            op_r <= ctrl_dp ? hwdata[2:0] : op_r;
            bcnt_r <= busy ? bcnt_r + 9'h001 : 9'h000;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_READY_OKAY: assert property (hreadyout && !hresp)
        else $error("bus stalled or not okay");
    AST_RDATA_IDLE: assert property (!(ap_r && !wr_r) |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    AST_FLAGS_HOLD: assert property (!scan_dp |=>
        $stable({ok_out, last_shifted_out_bit, test_out}))
        else $error("flags moved without a scan");
    AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(scan_dp))
        else $error("busy rose without a scan");
    AST_BUSY_MAX: assert property (bcnt_r <= 9'h101)
        else $error("busy too long");
    AST_INVERT_OK: assert property (scan_dp && !busy && en_r &&
        op_r == OP_INVERT |=> ok_out && busy)
        else $error("invert without success");
    AST_DIS_QUIET: assert property (scan_dp && !busy && !en_r |=>
        !(busy || ok_out || last_shifted_out_bit || test_out))
        else $error("disabled scan acted");
    AST_TEST_NORUN: assert property (scan_dp && !busy &&
        op_r == OP_TEST |=> !busy && !ok_out)
        else $error("bit test started a run");
    AST_OK_TEST_EXCL: assert property (!(ok_out && test_out))
        else $error("success and test both high");
endmodule : bitstr_unit_monitor

bind bitstr_unit bitstr_unit_monitor mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy),
    .ok_out(ok_out), .last_shifted_out_bit(last_shifted_out_bit),
    .test_out(test_out));

// ---- tb/bitstr_unit_tb_top.sv ----
// Table-driven bench for the bit-string unit.
// Assumes the scan host model drives the bus; hready is looped back.
`timescale 1ns/10ps
module bitstr_unit_tb_top
    import bitstr_pkg::*;
;
    typedef struct packed {
        logic [11:0] c;
        logic l;
        logic [15:0] n;
        logic [15:0] b;
        logic [31:0] s;
        logic [31:0] r;
        logic [2:0] f;
        logic w;
    } row_t;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, fill_bit_in;
    logic busy, ok_out, last_shifted_out_bit, test_out;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] v;
    int bad_count = 0;
    int cmp_count = 0;
    // Rotate counts stay inside the string except in refusal rows
    row_t rows [14] = '{
        '{12'h100, 1, 0, 0, 32'h1234a5f0, 32'hedcb5a0f, 1, 1},
        '{12'h101, 1, 4, 0, 32'h91234567, 32'h1234567f, 2, 1},
        '{12'h132, 1, 8, 0, 32'h91234567, 32'hff912345, 0, 1},
        '{12'h131, 0, 0, 0, 32'h00c3, 32'h00c3, 2, 1},
        '{12'h102, 0, 17, 0, 32'h1234, 32'hffff, 2, 1},
        '{12'h121, 0, 16, 0, 32'h0001, 32'h0, 2, 1},
        '{12'h103, 1, 3, 0, 32'hf0000001, 32'h8000000f, 1, 1},
        '{12'h104, 1, 5, 0, 32'h31, 32'h88000001, 1, 1},
        '{12'h103, 1, 33, 0, 32'h1, 32'h0, 0, 0},
        '{12'h104, 1, 16'hffff, 0, 32'h1, 32'h0, 0, 0},
        '{12'h105, 1, 0, 17, 32'h10000, 32'h0, 4, 0},
        '{12'h105, 1, 0, 33, 32'hffffffff, 32'h0, 0, 0},
        '{12'h105, 1, 0, 32, 32'hffffffff, 32'h0, 4, 0},
        '{12'h005, 1, 0, 32, 32'hffffffff, 32'h0, 0, 0}
    };
    bitstr_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .fill_bit_in(fill_bit_in),
        .busy(busy), .ok_out(ok_out), .test_out(test_out),
        .last_shifted_out_bit(last_shifted_out_bit));
    scan_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .fill_bit_in(fill_bit_in));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task end_sim(input int fail);
        bad_count += fail;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    task run(input row_t r);
        int k;
        host.xfer(1, 12'h400, {16'h0, r.s[15:0]}, v);
        host.xfer(1, 12'h404, {16'h0, r.s[31:16]}, v);
        host.xfer(1, CTRL_OFF, {20'h0, r.c}, v);
        host.xfer(1, LEN_OFF, {31'h0, r.l}, v);
        host.xfer(1, COUNT_OFF, {16'h0, r.n}, v);
        host.xfer(1, BITNUM_OFF, {16'h0, r.b}, v);
        host.xfer(1, SCAN_OFF, 32'h1, v);
        k = 0;
        do begin
            host.xfer(0, STATUS_OFF, 32'h0, v);
            k++;
        end while (v[STAT_BUSY] !== 1'b0 && k < 300);
        if (v[STAT_BUSY] !== 1'b0)
            end_sim(1);
        chk(32'(v[3:1]), 32'(r.f));
        chk(32'({test_out, last_shifted_out_bit, ok_out}), 32'(r.f));
        if (r.w) begin
            host.xfer(0, 12'h800, 32'h0, v);
            chk(v, {16'h0, r.r[15:0]});
        end
        if (r.w && r.l) begin
            host.xfer(0, 12'h804, 32'h0, v);
            chk(v, {16'h0, r.r[31:16]});
        end
    endtask : run
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        chk(32'({busy, ok_out, last_shifted_out_bit, test_out, hready,
            hresp}), 32'h2);
        for (int k = 0; k < 7; k++) begin
            // Offset 0x010 is the write-only strobe, 0x018 is unmapped
            host.xfer(0, 12'(4 * k), 32'h0, v);
            if (k != 4)
                chk(v, 32'h0);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            run(rows[i]);
            $display("test %0d done", i);
        end
        run('{12'h143, 0, 15, 0, 32'h3, 32'h8001, 1, 1});
        host.xfer(0, 12'h400, 32'h0, v);
        chk(v, 32'h8001);
        $display("test in place done");
        host.xfer(1, 12'h800, 32'h5555, v);
        run('{12'h000, 0, 0, 0, 32'h3, 32'h0, 0, 0});
        host.xfer(0, 12'h800, 32'h0, v);
        chk(v, 32'h8001);
        $display("test disabled done");
        host.fill_bit_in <= 1'b0;
        run('{12'h112, 0, 4, 0, 32'hf00f, 32'h0f00, 2, 1});
        $display("test fill port done");
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        chk(32'({busy, ok_out, last_shifted_out_bit, test_out}),
            32'h0);
        host.xfer(0, CTRL_OFF, 32'h0, v);
        chk(v, 32'h0);
        $display("test mid reset done");
        end_sim(0);
    end
endmodule : bitstr_unit_tb_top

// ---- tb/scan_host.sv ----
// Scan host model: AHB-Lite master and fill bit source.
// Assumes one slave; waits are bounded and end the run.
`timescale 1ns/10ps
module scan_host (
    // Clock and return
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Fill bit
    output logic fill_bit_in
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fill_bit_in = 1'b1;
    end
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 32);
        if (hready !== 1'b1)
            bitstr_unit_tb_top.end_sim(1);
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        // Stale write data would hide a late sample
        hwdata <= ~d;
    endtask : xfer
endmodule : scan_host

// ---- verilog/bitstr_pkg.sv ----
// Constants, types and register map of the bit-string unit.
// Assumes a single 32-bit AHB-Lite slave port in front of the unit.
package bitstr_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int WORD_W = 16;
    localparam int MAX_WORDS = 256;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] LEN_OFF = 12'h004;
    localparam logic [11:0] COUNT_OFF = 12'h008;
    localparam logic [11:0] BITNUM_OFF = 12'h00c;
    localparam logic [11:0] SCAN_OFF = 12'h010;
    localparam logic [11:0] STATUS_OFF = 12'h014;
    localparam logic [1:0] SRC_REGION = 2'h1;
    localparam logic [1:0] RES_REGION = 2'h2;

    // Field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_FILL_LSB = 4;
    localparam int CTRL_INPLACE = 6;
    localparam int CTRL_EN = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_OK = 1;
    localparam int STAT_FLOW = 2;
    localparam int STAT_TEST = 3;

    // Fill bit sources
    localparam logic [1:0] FILL_PORT = 2'h0;
    localparam logic [1:0] FILL_FALSE = 2'h2;
    localparam logic [1:0] FILL_TRUE = 2'h3;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        OP_INVERT, OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_TEST
    } op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_COPY} state_t;

    typedef struct packed {
        logic enable;
        logic in_place;
        logic [1:0] fill_src;
        logic [2:0] op;
    } ctrl_t;

    typedef struct packed {
        logic ok;
        logic flow;
        logic test;
    } flags_t;

    typedef struct packed {
        logic wr;
        logic [11:0] addr;
    } aphase_t;

    // Reset values
    localparam ctrl_t CTRL_RST = '0;
    localparam logic [7:0] LEN_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] BITNUM_RST = 16'h0000;

endpackage : bitstr_pkg

// ---- verilog/bitstr_unit.sv ----
// Bit-string invert, shift, rotate and bit test over word strings.
// Assumes one AHB-Lite master; hready is this slave's hreadyout.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/10ps

// How it works
// - Invert writes complement of the string
// - Invert reports success whenever enabled
// - Length selectable from 1 to 256 words
// - Left shift moves bits toward high end
// - Right shift moves bits toward low end
// - Every inserted bit equals the fill bit
// - Oversized shift fills result, flow gets fill
// - Zero shift copies string, flow gets fill
// - Flow holds the last bit shifted out
// - Whole shifted string written, in place optional
// - Left rotate re-enters high bits at low end
// - Right rotate re-enters low bits at high end
// - Rotate success low for bad count
// - Whole rotated string written, in place optional
// - Bit test reports the addressed bit
// - Bit test low when index out of range
// - Bit index re-read on every scan
// - Words form one string, bit 1 lowest
module bitstr_unit
    import bitstr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Scan flow
    input wire logic fill_bit_in,
    output logic busy,
    output logic ok_out,
    output logic last_shifted_out_bit,
    output logic test_out
);

    // ********************************************************
    // State
    // ********************************************************
    aphase_t ap_r, ap_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    ctrl_t ctrl_r, ctrl_nxt;
    logic [7:0] len_r, len_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] bitnum_r, bitnum_nxt;
    logic [WORD_W-1:0] src_r [MAX_WORDS];
    logic [WORD_W-1:0] src_nxt [MAX_WORDS];
    logic [WORD_W-1:0] res_r [MAX_WORDS];
    logic [WORD_W-1:0] res_nxt [MAX_WORDS];
    state_t state_r, state_nxt;
    logic [7:0] k_r, k_nxt;
    flags_t flags_r, flags_nxt;
    logic busy_r, busy_nxt;

    // ********************************************************
    // Operand decode
    // ********************************************************
    logic [8:0] len_w;
    logic [12:0] total;
    logic signed [17:0] n18, tot18, kb, raw, base;
    logic signed [13:0] lo, hi;
    logic [3:0] sh;
    logic [31:0] pair;
    logic [WORD_W-1:0] shift_word;
    logic fill, is_shift, is_rot, left, cnt_ok;
    logic [12:0] last_pos, test_pos;
    logic last_bit, test_bit, test_ok;

    // Bit 1 of the string is bit 0 of word 0
    function automatic logic get_bit(input logic [12:0] p);
        logic [WORD_W-1:0] w;
        w = src_r[p[11:4]];
        return w[p[3:0]];
    endfunction : get_bit

    assign len_w = {1'b0, len_r} + 9'h001;
    assign total = {len_w, 4'h0};
    assign n18 = {{2{cnt_r[15]}}, cnt_r};
    assign tot18 = {5'h00, total};
    assign is_shift = ctrl_r.op == OP_SHL || ctrl_r.op == OP_SHR;
    assign is_rot = ctrl_r.op == OP_ROL || ctrl_r.op == OP_ROR;
    assign left = ctrl_r.op == OP_SHL || ctrl_r.op == OP_ROL;
    assign cnt_ok = !cnt_r[15] && n18 <= tot18;

    always_comb begin
        case (ctrl_r.fill_src)
            FILL_FALSE: fill = 1'b0;
            FILL_TRUE: fill = 1'b1;
            default: fill = fill_bit_in;
        endcase
    end

    // Source position of bit 0 of output word k
    assign kb = {6'h00, k_r, 4'h0};
    assign raw = left ? kb - n18 : kb + n18;
    always_comb begin
        base = raw;
        if (is_rot && raw < 18'sd0) begin
            base = raw + tot18;
        end else if (is_rot && raw >= tot18) begin
            base = raw - tot18;
        end
    end
    assign lo = base[17:4];
    assign sh = base[3:0];
    // Rotate wraps the upper word back to word 0
    assign hi = (is_rot && lo + 14'sd1 == $signed({5'h00, len_w})) ?
        14'sd0 : lo + 14'sd1;
    assign pair = {src_r[hi[7:0]], src_r[lo[7:0]]};

    // One funnel per bit; positions off the string take the fill
    for (genvar j = 0; j < WORD_W; j++) begin : g_bit
        logic [4:0] sel;
        logic signed [13:0] wi;
        logic inr;
        assign sel = {1'b0, sh} + 5'(j);
        assign wi = sel[4] ? hi : lo;
        assign inr = !wi[13] && wi < $signed({5'h00, len_w});
        assign shift_word[j] = (is_rot || inr) ? pair[sel] : fill;
    end

    // Last departing bit: top n for left, bottom n for right
    assign last_pos = left ? total - cnt_r[12:0] : cnt_r[12:0] - 13'h0001;
    assign test_ok = bitnum_r != 16'h0000 && bitnum_r <= {3'h0, total};
    assign test_pos = bitnum_r[12:0] - 13'h0001;
    // Process form so a change of the stored string alone re-evaluates
    always_comb begin
        last_bit = get_bit(last_pos);
        test_bit = test_ok ? get_bit(test_pos) : 1'b0;
    end

    // ********************************************************
    // Bus decode and engine
    // ********************************************************
    logic take, wr_now, idle;
    logic [11:0] wa, ra;
    logic [31:0] rd_val;

    assign take = hsel && hready && htrans[1];
    assign wr_now = ap_r.wr;
    assign wa = ap_r.addr;
    assign ra = haddr[11:0];
    assign idle = state_r == ST_IDLE;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (ra[11:10] == SRC_REGION) begin
            rd_val = {16'h0000, src_r[ra[9:2]]};
        end else if (ra[11:10] == RES_REGION) begin
            rd_val = {16'h0000, res_r[ra[9:2]]};
        end else if (ra == CTRL_OFF) begin
            rd_val[CTRL_OP_LSB +: 3] = ctrl_r.op;
            rd_val[CTRL_FILL_LSB +: 2] = ctrl_r.fill_src;
            rd_val[CTRL_INPLACE] = ctrl_r.in_place;
            rd_val[CTRL_EN] = ctrl_r.enable;
        end else if (ra == LEN_OFF) begin
            rd_val = {24'h000000, len_r};
        end else if (ra == COUNT_OFF) begin
            rd_val = {16'h0000, cnt_r};
        end else if (ra == BITNUM_OFF) begin
            rd_val = {16'h0000, bitnum_r};
        end else if (ra == STATUS_OFF) begin
            rd_val[STAT_BUSY] = busy_r;
            rd_val[STAT_OK] = flags_r.ok;
            rd_val[STAT_FLOW] = flags_r.flow;
            rd_val[STAT_TEST] = flags_r.test;
        end
    end

    always_comb begin
        ap_nxt.wr = take && hwrite;
        ap_nxt.addr = haddr[11:0];
        hrdata_nxt = (take && !hwrite) ? rd_val : 32'h0000_0000;
        ctrl_nxt = ctrl_r;
        len_nxt = len_r;
        cnt_nxt = cnt_r;
        bitnum_nxt = bitnum_r;
        src_nxt = src_r;
        res_nxt = res_r;
        state_nxt = state_r;
        k_nxt = k_r;
        flags_nxt = flags_r;
        // Settings and source are frozen during a scan so the
        // engine never sees a half-updated operand
        if (wr_now && idle) begin
            if (wa[11:10] == SRC_REGION) begin
                src_nxt[wa[9:2]] = hwdata[15:0];
            end else if (wa == CTRL_OFF) begin
                ctrl_nxt.op = hwdata[CTRL_OP_LSB +: 3];
                ctrl_nxt.fill_src = hwdata[CTRL_FILL_LSB +: 2];
                ctrl_nxt.in_place = hwdata[CTRL_INPLACE];
                ctrl_nxt.enable = hwdata[CTRL_EN];
            end else if (wa == LEN_OFF) begin
                len_nxt = hwdata[7:0];
            end else if (wa == COUNT_OFF) begin
                cnt_nxt = hwdata[15:0];
            end else if (wa == BITNUM_OFF) begin
                bitnum_nxt = hwdata[15:0];
            end else if (wa == SCAN_OFF) begin
                flags_nxt = '0;
                if (ctrl_r.enable) begin
                    case (ctrl_r.op)
                        OP_INVERT: begin
                            flags_nxt.ok = 1'b1;
                            state_nxt = ST_RUN;
                        end
                        OP_SHL, OP_SHR: begin
                            // Negative count: no write, flow low
                            if (!cnt_r[15]) begin
                                state_nxt = ST_RUN;
                                if (cnt_r == 16'h0000 || !cnt_ok) begin
                                    flags_nxt.flow = fill;
                                end else begin
                                    flags_nxt.flow = last_bit;
                                end
                            end
                        end
                        OP_ROL, OP_ROR: begin
                            flags_nxt.ok = cnt_ok;
                            if (cnt_ok) begin
                                state_nxt = ST_RUN;
                            end
                        end
                        OP_TEST: begin
                            flags_nxt.test = test_bit;
                        end
                        default: begin
                            flags_nxt = '0;
                        end
                    endcase
                end
                k_nxt = 8'h00;
            end
        end
        case (state_r)
            ST_RUN: begin
                if (ctrl_r.op == OP_INVERT) begin
                    res_nxt[k_r] = ~src_r[k_r];
                end else begin
                    res_nxt[k_r] = shift_word;
                end
                k_nxt = k_r + 8'h01;
                if (k_r == len_r) begin
                    state_nxt = ctrl_r.in_place ? ST_COPY : ST_IDLE;
                end
            end
            ST_COPY: begin
                // Result lands in the source only after the whole
                // string is built, so in-place never reads its own
                // partial output
                src_nxt = res_r;
                state_nxt = ST_IDLE;
            end
            default: begin
            end
        endcase
        busy_nxt = state_nxt != ST_IDLE;
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_r <= '0;
            hrdata_r <= 32'h0000_0000;
            ctrl_r <= CTRL_RST;
            len_r <= LEN_RST;
            cnt_r <= COUNT_RST;
            bitnum_r <= BITNUM_RST;
            state_r <= ST_IDLE;
            k_r <= 8'h00;
            flags_r <= '0;
            busy_r <= 1'b0;
        end else begin
            ap_r <= ap_nxt;
            hrdata_r <= hrdata_nxt;
            ctrl_r <= ctrl_nxt;
            len_r <= len_nxt;
            cnt_r <= cnt_nxt;
            bitnum_r <= bitnum_nxt;
            state_r <= state_nxt;
            k_r <= k_nxt;
            flags_r <= flags_nxt;
            busy_r <= busy_nxt;
        end
    end

    // String storage has no reset; software loads it before use
    always_ff @(posedge hclk) begin
        src_r <= src_nxt;
        res_r <= res_nxt;
    end

    // Zero wait states; every answer is OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;
    assign busy = busy_r;
    assign ok_out = flags_r.ok;
    assign last_shifted_out_bit = flags_r.flow;
    assign test_out = flags_r.test;

endmodule : bitstr_unit
